// *** verilog/ftr_regs.v ***
// flash timer control and status/limit/indicator register pair
`timescale 1ns/100ps
`include "ftr_consts.vh"

module ftr_regs #(
  parameter TICK_CYCLES = `FTR_TICK_CYCLES
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [1:0] mode_ctrl,
  input wire flash_trigger,
  input wire tx_blank_in,
  input wire high_current_sel,
  input wire led_open_short,
  input wire regulation_ok,
  input wire [1:0] die_temp_in,
  input wire thermal_trip,
  input wire gpio_value,
  output reg flash_on,
  output reg dc_level_force,
  output reg gpio_out,
  output reg [1:0] valley_limit_code,
  output reg [1:0] privacy_led_channel,
  output reg [2:0] hc_led_pwm
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [2:0] safety_duration_sel;
  reg timer_range_sel;
  reg timer_trigger_type;
  reg blank_enable;
  reg strobe_active;
  reg timeout_flag;
  reg led_fault_flag;
  reg blank_flag;
  reg trip_flag;
  reg regulation_ok_select;
  reg valley_limit_sel;
  reg [3:0] indicator_ctrl;
  reg trigger_d;

  wire wr_ctrl;
  wire wr_stat;
  wire rd_ctrl;
  wire rd_stat;
  wire dc_flash_mode;
  wire trig_rise;
  wire sw_start;
  wire pin_start;
  wire pin_stop;
  wire strobe_start;
  wire expired;
  wire blank_now;
  wire pwm_bit;
  reg [`FTR_CNT_W-1:0] limit;
  reg [7:0] next_rdata;
  reg [1:0] die_temp_level;
  reg [1:0] next_limit;
  reg next_strobe_active;
  reg next_timeout_flag;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign wr_ctrl = reg_wr && (reg_addr == `FTR_ADDR_TIMER_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `FTR_ADDR_STATUS);
  assign rd_ctrl = reg_rd && (reg_addr == `FTR_ADDR_TIMER_CTRL);
  assign rd_stat = reg_rd && (reg_addr == `FTR_ADDR_STATUS);

  // ----------------------------------------
  // strobe start and stop
  // ----------------------------------------
  assign dc_flash_mode = (mode_ctrl == `FTR_MODE_DC_FLASH);
  assign trig_rise = flash_trigger && !trigger_d;
  assign sw_start = wr_ctrl && reg_wdata[`FTR_STROBE_BIT];
  // pin trigger only acts in mode 10; edge type starts once, level type follows the pin
  assign pin_start = dc_flash_mode && trig_rise;
  assign pin_stop = dc_flash_mode && !timer_trigger_type && !flash_trigger
    && trigger_d;
  assign strobe_start = (sw_start || pin_start) && !strobe_active;
  assign blank_now = blank_enable && tx_blank_in;

  always @* begin
    if (!timer_range_sel) begin
      case (safety_duration_sel)
        3'h0: limit = `FTR_T0_0;
        3'h1: limit = `FTR_T0_1;
        3'h2: limit = `FTR_T0_2;
        3'h3: limit = `FTR_T0_3;
        3'h4: limit = `FTR_T0_4;
        3'h5: limit = `FTR_T0_5;
        3'h6: limit = `FTR_T0_6;
        default: limit = `FTR_T0_7;
      endcase
    end else begin
      case (safety_duration_sel)
        3'h0: limit = `FTR_T1_0;
        3'h1: limit = `FTR_T1_1;
        3'h2: limit = `FTR_T1_2;
        3'h3: limit = `FTR_T1_3;
        3'h4: limit = `FTR_T1_4;
        3'h5: limit = `FTR_T1_5;
        3'h6: limit = `FTR_T1_6;
        default: limit = `FTR_T1_7;
      endcase
    end
  end

  ftr_safety_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .restart(strobe_start),
    .run(strobe_active),
    .limit(limit),
    .expired(expired)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    // a trip in the read cycle itself is shown at once, not one read later
    die_temp_level = (trip_flag || thermal_trip) ? `FTR_TEMP_TRIP : die_temp_in;
    next_rdata = 8'h00;
    if (reg_addr == `FTR_ADDR_TIMER_CTRL) begin
      next_rdata[`FTR_DUR_HI:`FTR_DUR_LO] = safety_duration_sel;
      next_rdata[`FTR_FAULT_BIT] = led_fault_flag;
      next_rdata[`FTR_RANGE_BIT] = timeout_flag;
      next_rdata[`FTR_TRIG_BIT] = timer_trigger_type;
      next_rdata[`FTR_STROBE_BIT] = strobe_active;
      next_rdata[`FTR_BLANK_BIT] = blank_flag;
    end else if (reg_addr == `FTR_ADDR_STATUS) begin
      next_rdata[`FTR_PG_BIT] = regulation_ok;
      next_rdata[`FTR_TEMP_HI:`FTR_TEMP_LO] = die_temp_level;
      next_rdata[`FTR_VALLEY_LIMIT_SEL_BIT] = valley_limit_sel;
      next_rdata[`FTR_IND_HI:`FTR_IND_LO] = indicator_ctrl;
    end
  end

  // ----------------------------------------
  // valley current limit code
  // ----------------------------------------
  always @* begin
    if (high_current_sel && tx_blank_in) begin
      next_limit = valley_limit_sel ? `FTR_LIM_500 : `FTR_LIM_250;
    end else if (!high_current_sel && !tx_blank_in && valley_limit_sel) begin
      next_limit = `FTR_LIM_1750;
    end else begin
      next_limit = `FTR_LIM_1250;
    end
  end

  // ----------------------------------------
  // flash timer control register writes
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      safety_duration_sel <= `FTR_DUR_RESET;
      timer_range_sel <= 1'b0;
      timer_trigger_type <= 1'b0;
      blank_enable <= 1'b1;
    end else if (wr_ctrl) begin
      safety_duration_sel <= reg_wdata[`FTR_DUR_HI:`FTR_DUR_LO];
      timer_range_sel <= reg_wdata[`FTR_RANGE_BIT];
      timer_trigger_type <= reg_wdata[`FTR_TRIG_BIT];
      blank_enable <= reg_wdata[`FTR_BLANK_BIT];
    end
  end

  // ----------------------------------------
  // status, limit and indicator register writes
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      regulation_ok_select <= 1'b0;
      valley_limit_sel <= 1'b0;
      indicator_ctrl <= 4'h0;
    end else if (wr_stat) begin
      regulation_ok_select <= reg_wdata[`FTR_PG_BIT];
      // no shutdown gating here: the host is trusted to write this before operation
      valley_limit_sel <= reg_wdata[`FTR_VALLEY_LIMIT_SEL_BIT];
      indicator_ctrl <= reg_wdata[`FTR_IND_HI:`FTR_IND_LO];
    end
  end

  // ----------------------------------------
  // trigger pin delay for edge detection
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      trigger_d <= 1'b0;
    end else begin
      trigger_d <= flash_trigger;
    end
  end

  // ----------------------------------------
  // strobe state and timeout flag
  // ----------------------------------------
  always @* begin
    next_strobe_active = strobe_active;
    next_timeout_flag = timeout_flag;
    if (strobe_start) begin
      next_strobe_active = 1'b1;
      next_timeout_flag = 1'b0;
    end else if (expired) begin
      next_strobe_active = 1'b0;
      next_timeout_flag = 1'b1;
    end else if (pin_stop) begin
      // level type: the strobe ends with the pin, the timeout flag is left alone
      next_strobe_active = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      strobe_active <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      strobe_active <= next_strobe_active;
      timeout_flag <= next_timeout_flag;
    end
  end

  // ----------------------------------------
  // clear-on-read flags; a set always wins over a read clear
  // ----------------------------------------
  // the read edge counts as the completed read, so an event on that edge still sets
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      led_fault_flag <= 1'b0;
    end else if (led_open_short) begin
      led_fault_flag <= 1'b1;
    end else if (rd_ctrl) begin
      led_fault_flag <= 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      blank_flag <= 1'b0;
    end else if (blank_now) begin
      blank_flag <= 1'b1;
    end else if (rd_ctrl) begin
      blank_flag <= 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      trip_flag <= 1'b0;
    end else if (thermal_trip) begin
      trip_flag <= 1'b1;
    end else if (rd_stat) begin
      trip_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // privacy indicator
  // ----------------------------------------
  ftr_ind_pwm u_pwm (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(indicator_ctrl[`FTR_IND_TOP]),
    .duty_sel(indicator_ctrl[2:0]),
    .pwm_out(pwm_bit)
  );

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      // held between reads so the host may take it at leisure
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // led drive and gpio outputs
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      flash_on <= 1'b0;
      dc_level_force <= 1'b0;
      gpio_out <= 1'b0;
    end else begin
      // expiry drops the flash level in the same edge the strobe ends
      flash_on <= strobe_active && !expired && !blank_now;
      dc_level_force <= blank_now;
      gpio_out <= regulation_ok_select ? gpio_value : regulation_ok;
    end
  end

  // ----------------------------------------
  // limit and indicator outputs
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      valley_limit_code <= `FTR_LIM_1250;
      privacy_led_channel <= 2'h0;
      hc_led_pwm <= 3'h0;
    end else begin
      valley_limit_code <= next_limit;
      privacy_led_channel <= indicator_ctrl[`FTR_IND_TOP] ? 2'h0 : indicator_ctrl[1:0];
      // gated again here: the pwm stage lags the register by a cycle
      hc_led_pwm <= {3{pwm_bit && indicator_ctrl[`FTR_IND_TOP]}};
    end
  end

endmodule // ftr_regs

// *** verilog/ftr_consts.vh ***
// constants for the flash timer and status register pair
`ifndef FTR_CONSTS_VH
`define FTR_CONSTS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define FTR_ADDR_TIMER_CTRL 8'h03
`define FTR_ADDR_STATUS 8'h04
`define FTR_TIMER_CTRL_RESET 8'hc1
`define FTR_STATUS_RESET 8'h00

// ----------------------------------------
// flash_timer_control fields
// ----------------------------------------
`define FTR_DUR_HI 7
`define FTR_DUR_LO 5
`define FTR_FAULT_BIT 4
`define FTR_RANGE_BIT 3
`define FTR_TRIG_BIT 2
`define FTR_STROBE_BIT 1
`define FTR_BLANK_BIT 0
`define FTR_DUR_RESET 3'h6

// ----------------------------------------
// status_limit_indicator fields
// ----------------------------------------
`define FTR_PG_BIT 7
`define FTR_TEMP_HI 6
`define FTR_TEMP_LO 5
`define FTR_VALLEY_LIMIT_SEL_BIT 4
`define FTR_IND_HI 3
`define FTR_IND_LO 0
`define FTR_IND_TOP 3
`define FTR_TEMP_TRIP 2'h3

// ----------------------------------------
// modes and limit codes
// ----------------------------------------
`define FTR_MODE_DC_FLASH 2'h2
`define FTR_LIM_1250 2'h0
`define FTR_LIM_1750 2'h1
`define FTR_LIM_250 2'h2
`define FTR_LIM_500 2'h3

// ----------------------------------------
// timing: timer counts in 100 us ticks
// ----------------------------------------
`define FTR_CLK_HZ 50000000
`define FTR_TICK_US 100
`define FTR_TICK_CYCLES ((`FTR_CLK_HZ / 1000000) * `FTR_TICK_US)
`define FTR_CNT_W 14
`define FTR_T0_0 14'd682
`define FTR_T0_1 14'd1022
`define FTR_T0_2 14'd1363
`define FTR_T0_3 14'd1704
`define FTR_T0_4 14'd2045
`define FTR_T0_5 14'd3408
`define FTR_T0_6 14'd5793
`define FTR_T0_7 14'd8520
`define FTR_T1_0 14'd53
`define FTR_T1_1 14'd107
`define FTR_T1_2 14'd160
`define FTR_T1_3 14'd213
`define FTR_T1_4 14'd266
`define FTR_T1_5 14'd320
`define FTR_T1_6 14'd373
`define FTR_T1_7 14'd2077

// ----------------------------------------
// indicator pwm: period and duties in 0.1 percent steps
// ----------------------------------------
`define FTR_PWM_W 10
`define FTR_PWM_PERIOD 10'd1000
`define FTR_PWM_D0 10'd8
`define FTR_PWM_D1 10'd16
`define FTR_PWM_D2 10'd23
`define FTR_PWM_D3 10'd31
`define FTR_PWM_D4 10'd39
`define FTR_PWM_D5 10'd47
`define FTR_PWM_D6 10'd63
`define FTR_PWM_D7 10'd86

`endif

// *** verilog/ftr_safety_timer.v ***
// strobe safety timer with its own 100 us tick divider
`timescale 1ns/100ps
`include "ftr_consts.vh"

module ftr_safety_timer #(
  parameter TICK_CYCLES = `FTR_TICK_CYCLES
) (
  input wire ref_clk,
  input wire reset_n,
  input wire restart,
  input wire run,
  input wire [`FTR_CNT_W-1:0] limit,
  output reg expired
);

  reg [15:0] div_cnt;
  reg [`FTR_CNT_W-1:0] tick_cnt;
  wire tick;

  assign tick = (div_cnt == TICK_CYCLES[15:0] - 16'h0001);

  // ----------------------------------------
  // divider and tick counter
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      div_cnt <= 16'h0000;
      tick_cnt <= {`FTR_CNT_W{1'b0}};
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (restart || !run) begin
        // restart realigns the divider so the first tick is a full one
        div_cnt <= 16'h0000;
        tick_cnt <= {`FTR_CNT_W{1'b0}};
      end else if (tick) begin
        div_cnt <= 16'h0000;
        if (tick_cnt + 14'h0001 >= limit) begin
          expired <= 1'b1;
          tick_cnt <= {`FTR_CNT_W{1'b0}};
        end else begin
          tick_cnt <= tick_cnt + 14'h0001;
        end
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

endmodule // ftr_safety_timer

// *** verilog/ftr_ind_pwm.v ***
// pwm dimming generator for the privacy indicator on the led channels
`timescale 1ns/100ps
`include "ftr_consts.vh"

module ftr_ind_pwm (
  input wire ref_clk,
  input wire reset_n,
  input wire enable,
  input wire [2:0] duty_sel,
  output reg pwm_out
);

  reg [`FTR_PWM_W-1:0] phase;
  reg [`FTR_PWM_W-1:0] duty;

  always @* begin
    case (duty_sel)
      3'h0: duty = `FTR_PWM_D0;
      3'h1: duty = `FTR_PWM_D1;
      3'h2: duty = `FTR_PWM_D2;
      3'h3: duty = `FTR_PWM_D3;
      3'h4: duty = `FTR_PWM_D4;
      3'h5: duty = `FTR_PWM_D5;
      3'h6: duty = `FTR_PWM_D6;
      default: duty = `FTR_PWM_D7;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      phase <= {`FTR_PWM_W{1'b0}};
      pwm_out <= 1'b0;
    end else begin
      if (phase == `FTR_PWM_PERIOD - 10'd1) begin
        phase <= {`FTR_PWM_W{1'b0}};
      end else begin
        phase <= phase + 10'd1;
      end
      pwm_out <= enable && (phase < duty);
    end
  end

endmodule // ftr_ind_pwm

// *** test/ftr_regs_props.sv ***
// checker for the flash timer and status register pair
`timescale 1ns/100ps
`include "ftr_consts.vh"
module ftr_regs_props #(
  parameter TICK_CYCLES = 4
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire tx_blank_in,
  input wire high_current_sel,
  input wire led_open_short,
  input wire regulation_ok,
  input wire thermal_trip,
  input wire gpio_value,
  input wire flash_on,
  input wire dc_level_force,
  input wire gpio_out,
  input wire [1:0] valley_limit_code,
  input wire [1:0] privacy_led_channel,
  input wire [2:0] hc_led_pwm
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire rd3 = reg_rd && reg_addr == `FTR_ADDR_TIMER_CTRL;
  wire rd4 = reg_rd && reg_addr == `FTR_ADDR_STATUS;
  wire both_hi = high_current_sel && tx_blank_in;
  wire same_src = regulation_ok == gpio_value;
  wire start_wr = reg_wr && reg_addr == `FTR_ADDR_TIMER_CTRL && reg_wdata[1] && !reg_wdata[0];
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_pg_readback: assert property (rd4 |=> reg_rdata[7] == $past(regulation_ok))
    else $error("power good read wrong");
  chk_trip_reads: assert property (rd4 && thermal_trip |=> reg_rdata[6:5] == 2'h3)
    else $error("trip code lost");
  chk_fault_reads: assert property (led_open_short ##1 rd3 |=> reg_rdata[4])
    else $error("led fault not reported");
  chk_blank_cut: assert property (!tx_blank_in |=> !dc_level_force)
    else $error("dc level forced without blanking input");
  chk_gpio_route: assert property ($past(reset_n) && same_src
    |=> gpio_out == $past(gpio_value))
    else $error("gpio output wrong");
  chk_limit_low: assert property (!both_hi |=> !valley_limit_code[1])
    else $error("reduced limit without both inputs");
  chk_limit_high: assert property ($past(reset_n) && both_hi |=> valley_limit_code[1])
    else $error("reduced limit missing");
  chk_ind_excl: assert property (privacy_led_channel != 2'h0 |-> hc_led_pwm == 3'h0)
    else $error("both indicator paths active");
  chk_pwm_same: assert property (hc_led_pwm == 3'h0 || hc_led_pwm == 3'h7)
    else $error("led channels dim apart");
  chk_strobe_start: assert property ($past(reset_n) && start_wr && !flash_on
    |=> ##1 flash_on)
    else $error("strobe did not start");
  cov_fall: cover property ($fell(flash_on));
  cov_trip: cover property (rd4 && thermal_trip);
  cov_both: cover property (both_hi);
  cov_pwm: cover property (hc_led_pwm == 3'h7);
endmodule // ftr_regs_props
bind ftr_regs ftr_regs_props #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);

// *** test/ftr_host_model.sv ***
// host model driving the register port
`timescale 1ns/100ps
module ftr_host_model (
  input wire ref_clk,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  // ----
  // transfers
  // ----
  initial begin
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // called just after an edge; held until the taking edge
  task xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    begin
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = wr;
      reg_rd = !wr;
      @(posedge ref_clk);
      #1;
    end
  endtask
  // released lines show the inverse so stale values never look live
  task idle;
    begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule // ftr_host_model

// *** test/tb_flash_timer_status_regs.sv ***
// testbench for the flash timer and status register pair
`timescale 1ns/100ps
`include "ftr_consts.vh"
module tb_flash_timer_status_regs;
  // ----
  // bench
  // ----
  localparam TICKS = 4;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [1:0] mode_ctrl = 2'h0;
  reg flash_trigger = 1'b0;
  reg tx_blank_in = 1'b0;
  reg high_current_sel = 1'b0;
  reg led_open_short = 1'b0;
  reg regulation_ok = 1'b0;
  reg [1:0] die_temp_in = 2'h1;
  reg thermal_trip = 1'b0;
  reg gpio_value = 1'b0;
  reg rd_d = 1'b0;
  reg prev_ok = 1'b0;
  reg prev_gv = 1'b0;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire reg_wr;
  wire reg_rd;
  wire [7:0] reg_rdata;
  wire flash_on;
  wire dc_level_force;
  wire gpio_out;
  wire [1:0] valley_limit_code;
  wire [1:0] privacy_led_channel;
  wire [2:0] hc_led_pwm;
  integer bad_count = 0;
  integer checked = 0;
  integer n;
  integer i;
  integer j;
  logic [7:0] m;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  ftr_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  ftr_regs #(.TICK_CYCLES(TICKS)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_ctrl(mode_ctrl), .flash_trigger(flash_trigger),
    .tx_blank_in(tx_blank_in), .high_current_sel(high_current_sel),
    .led_open_short(led_open_short), .regulation_ok(regulation_ok),
    .die_temp_in(die_temp_in), .thermal_trip(thermal_trip), .gpio_value(gpio_value),
    .flash_on(flash_on), .dc_level_force(dc_level_force), .gpio_out(gpio_out),
    .valley_limit_code(valley_limit_code), .privacy_led_channel(privacy_led_channel),
    .hc_led_pwm(hc_led_pwm));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    prev_ok <= regulation_ok;
    prev_gv <= gpio_value;
    rd_d <= reg_rd;
    #1;
    regulation_ok = 1'($urandom);
    gpio_value = 1'($urandom);
  end
  // read data lands at the taking edge and is checked 2 ns after that same edge
  always @(posedge ref_clk) begin
    #2;
    if (rd_d) begin
      m = msk_q.pop_front();
      chk(reg_rdata & m, exp_q.pop_front() & m, "read data");
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge ref_clk);
      #1;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      host_u.xfer(1'b1, a, d);
      host_u.idle;
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    begin
      exp_q.push_back(e);
      msk_q.push_back(mk);
      host_u.xfer(1'b0, a, 8'h00);
      host_u.idle;
    end
  endtask
  task chk_gpio(input logic sel);
    begin
      repeat (4) begin
        cyc(1);
        chk({7'h0, gpio_out}, {7'h0, sel ? prev_gv : prev_ok}, "gpio");
      end
    end
  endtask
  task wait_fall;
    begin
      n = 0;
      while (flash_on === 1'b1 && n < 10000) begin
        cyc(1);
        n = n + 1;
      end
    end
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up;
  end
  initial begin
    n = $urandom(62);
    cyc(4);
    reset_n = 1'b1;
    rd(`FTR_ADDR_TIMER_CTRL, 8'hc0, 8'hff);
    rd(`FTR_ADDR_STATUS, 8'h00, 8'h1f);
    rd(8'h07, 8'h00, 8'hff);
    chk({6'h0, valley_limit_code}, 8'h00, "limit reset");
    done("reset");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`FTR_ADDR_STATUS, {3'h0, i[0], 4'h3});
      rd(`FTR_ADDR_STATUS, {3'h0, i[0], 4'h3}, 8'h1f);
      chk_gpio(1'b0);
      for (j = 0; j < 4; j = j + 1) begin
        high_current_sel = j[0];
        tx_blank_in = j[1];
        cyc(2);
        chk({6'h0, valley_limit_code}, {6'h0, j == 3, i[0] && j % 3 == 0}, "limit");
      end
      chk({6'h0, privacy_led_channel}, 8'h03, "indicator");
    end
    high_current_sel = 1'b0;
    tx_blank_in = 1'b0;
    done("limit");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`FTR_ADDR_STATUS, i ? 8'h8f : 8'h88);
      cyc(4);
      n = 0;
      repeat (1000) begin
        cyc(1);
        n = n + hc_led_pwm[1];
      end
      chk(n[7:0], i ? 8'h56 : 8'h08, "pwm duty");
      chk({6'h0, privacy_led_channel}, 8'h00, "indicator off");
    end
    chk_gpio(1'b1);
    done("indicator");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`FTR_ADDR_TIMER_CTRL, i ? 8'h02 : 8'h0a);
      cyc(1);
      chk({7'h0, flash_on}, 8'h01, "strobe on");
      wait_fall;
      j = (i ? 682 : 53) * TICKS;
      chk({7'h0, n > j - 8 && n < j + 4}, 8'h01, "timeout span");
      rd(`FTR_ADDR_TIMER_CTRL, 8'h08, 8'h0a);
    end
    done("timer");
    mode_ctrl = `FTR_MODE_DC_FLASH;
    wr(`FTR_ADDR_TIMER_CTRL, 8'he8);
    flash_trigger = 1'b1;
    cyc(3);
    rd(`FTR_ADDR_TIMER_CTRL, 8'h02, 8'h0a);
    flash_trigger = 1'b0;
    cyc(3);
    chk({7'h0, flash_on}, 8'h00, "level end");
    wr(`FTR_ADDR_TIMER_CTRL, 8'h0c);
    flash_trigger = 1'b1;
    cyc(1);
    flash_trigger = 1'b0;
    cyc(20);
    chk({7'h0, flash_on}, 8'h01, "edge run");
    wait_fall;
    chk({7'h0, n > 150 && n < 250}, 8'h01, "edge timeout");
    mode_ctrl = 2'h1;
    flash_trigger = 1'b1;
    cyc(5);
    chk({7'h0, flash_on}, 8'h00, "pin ignored");
    flash_trigger = 1'b0;
    done("trigger");
    wr(`FTR_ADDR_TIMER_CTRL, 8'h01);
    tx_blank_in = 1'b1;
    led_open_short = 1'b1;
    thermal_trip = 1'b1;
    cyc(2);
    chk({7'h0, dc_level_force}, 8'h01, "blanking");
    tx_blank_in = 1'b0;
    rd(`FTR_ADDR_STATUS, 8'h60, 8'h60);
    led_open_short = 1'b0;
    thermal_trip = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      rd(`FTR_ADDR_TIMER_CTRL, i ? 8'h00 : 8'h11, 8'h11);
      rd(`FTR_ADDR_STATUS, i ? 8'h20 : 8'h60, 8'h60);
    end
    cyc(3);
    done("flags");
    wrap_up;
  end
endmodule // tb_flash_timer_status_regs
